// >>> design/mdmirq_pkg.sv
// shared constants and carrier types for the modem interrupt mask and control block
`default_nettype none

package mdmirq_pkg;

   // register addresses on the serial register interface
   localparam logic [7:0]  STATUS_ADDR   = 8'h20;
   localparam logic [7:0]  MASK_ADDR     = 8'h21;
   localparam logic [7:0]  CTRL_ADDR     = 8'h22;

   // reset values
   localparam logic [15:0] MASK_RESET    = 16'h0024;
   localparam logic [15:0] CTRL_RESET    = 16'h0048;
   localparam logic [15:0] STATUS_RESET  = 16'h0000;

   // writable bits; everything else is reserved and reads zero
   localparam logic [15:0] MASK_WRITABLE = 16'h7fff;
   localparam logic [15:0] CTRL_WRITABLE = 16'hf1fd;

   // status field positions
   localparam int          STICKY_LSB    = 8;
   localparam int          STICKY_MSB    = 12;
   localparam int          EVENT_MSB     = 14;

   // transmit amplitude step in mVpp per code
   localparam logic [9:0]  AMP_STEP_MVPP = 10'h019;
   localparam logic [3:0]  PREAMBLE_BIAS = 4'h1;

   // events from the surrounding modem, same clock
   typedef struct packed {
      logic talk_limit_expired;
      logic talk_limit_triggered;
      logic gap_error;
      logic frame_error;
      logic parity_error;
      logic host_timeout_event;
      logic crc_error;
      logic rx_queue_level;
      logic rx_queue_full;
      logic rx_queue_empty;
      logic tx_queue_level;
      logic tx_queue_full;
      logic tx_queue_empty;
      logic carrier_detect;
   } mdmirq_evt_t;

   // control register layout, bit 15 down to bit 0
   typedef struct packed {
      logic       manchester_polarity;
      logic [2:0] preamble_code;
      logic [2:0] rsv_hi;
      logic [4:0] transmit_amplitude;
      logic       modem_enable;
      logic       fifo_loopback;
      logic       rsv_lo;
      logic       request_to_send;
   } mdmirq_ctrl_t;

   // one register access from the serial interface front end
   typedef struct packed {
      logic        wr_en;
      logic        rd_en;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } mdmirq_req_t;

endpackage

`default_nettype wire

// >>> design/mdmirq_irq_gen.sv
// interrupt pin generation from status and mask, pulse or level mode
`default_nettype none

module mdmirq_irq_gen (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [15:0] status,
   input  wire logic [15:0] mask,
   input  wire logic        level_mode,
   input  wire logic        active_low,
   input  wire logic        status_read,
   output var  logic        irq_pin,
   output var  logic        irq_request
);
   import mdmirq_pkg::*;

   logic [EVENT_MSB:0] pending;
   logic [EVENT_MSB:0] prev_pending;
   logic               new_event;
   logic               hold;
   logic               next_hold;
   logic               assert_now;

   assign pending    = status[EVENT_MSB:0] & ~mask[EVENT_MSB:0];
   assign new_event  = |(pending & ~prev_pending);
   // a new event in the read cycle keeps the level asserted; pulse mode keeps
   // nothing, so a later switch to level mode raises no stale interrupt
   assign next_hold  = level_mode & (new_event | (hold & ~status_read));
   assign assert_now = level_mode ? next_hold : new_event;

   always_ff @(posedge clk) begin
      if (reset) begin
         prev_pending <= '0;
      end else begin
         prev_pending <= pending;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         hold <= 1'b0;
      end else begin
         hold <= next_hold;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         irq_pin     <= active_low;
         irq_request <= 1'b0;
      end else begin
         irq_pin     <= assert_now ^ active_low;
         irq_request <= |pending;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   chk_pulse_on_event: assert property (!level_mode && new_event |=> (irq_pin ^ active_low))
      else $error("pulse mode event gave no pulse");
   chk_pulse_single: assert property (!level_mode && !new_event |=> !(irq_pin ^ active_low))
      else $error("pulse mode pin asserted without event");
   chk_level_hold: assert property (level_mode && hold && !status_read ##1 level_mode |-> (irq_pin ^ active_low))
      else $error("level mode released before status read");
   chk_masked_quiet: assert property (pending == '0 |=> !irq_request)
      else $error("masked event raised request");
   chk_request_or: assert property (|(status[EVENT_MSB:0] & ~mask[EVENT_MSB:0]) |=> irq_request)
      else $error("unmasked event did not raise request");

   cov_level_irq: cover property (level_mode && new_event ##1 (irq_pin ^ active_low) [*3] ##1 status_read);
   cov_pulse_irq: cover property (!level_mode && new_event ##1 (irq_pin ^ active_low));

endmodule

`default_nettype wire

// >>> design/mdmirq_top.sv
// interrupt mask, status and modem control registers of the field modem
`default_nettype none

//
// Contract
// - cleared mask bit lets its status event drive the interrupt pin
// - set mask bit blocks the pin; event still shows in status
// - mask bits 14..0 each gate the status event at the same position
// - mask register resets to 0x0024, both queue empty events masked
// - polarity bit 15: 0 sends one high-to-low, 1 sends low-to-high
// - manchester mode sends preamble field plus one preamble bytes
// - five-bit amplitude code in 25 mVpp steps, reset code four
// - modem enable bit 3 enables transmit and receive; clear disables both
// - loopback bit 2 feeds transmit queue into receive queue when set
// - control bit 0 raises request to send when set
// - control register resets to 0x0048
// - event bits stay set until written one; live bits follow conditions
// - clear to send follows request with no carrier, unless full duplex; code also requires modem enable
// - level mode holds pin until status read; else pulse per event
module mdmirq_top (
   input  wire logic                     clk,
   input  wire logic                     reset,
   input  wire mdmirq_pkg::mdmirq_req_t  reg_req,
   output var  logic [15:0]              reg_rdata,
   output var  logic                     reg_rd_valid,
   input  wire mdmirq_pkg::mdmirq_evt_t  events,
   input  wire logic                     irq_level_mode,
   input  wire logic                     irq_active_low,
   output var  logic                     irq_pin,
   output var  logic                     irq_request,
   output var  mdmirq_pkg::mdmirq_ctrl_t ctrl,
   output var  logic [3:0]               preamble_byte_count,
   output var  logic [9:0]               amplitude_mvpp,
   output var  logic                     tx_enable,
   output var  logic                     rx_enable,
   output var  logic                     loopback_enable,
   output var  logic                     clear_to_send
);
   import mdmirq_pkg::*;

   logic [15:0]                  mask;
   logic [STICKY_MSB:STICKY_LSB] sticky;
   logic [STICKY_MSB:STICKY_LSB] sticky_set;
   logic [STICKY_MSB:STICKY_LSB] sticky_clr;
   logic [STICKY_MSB:STICKY_LSB] next_sticky;
   logic [15:0]                  status;
   logic                         next_cts;
   logic                         status_read;
   logic                         wr_status;
   logic                         wr_mask;
   logic                         wr_ctrl;
   logic [15:0]                  next_rdata;

   assign wr_status   = reg_req.wr_en && (reg_req.addr == STATUS_ADDR);
   assign wr_mask     = reg_req.wr_en && (reg_req.addr == MASK_ADDR);
   assign wr_ctrl     = reg_req.wr_en && (reg_req.addr == CTRL_ADDR);
   assign status_read = reg_req.rd_en && (reg_req.addr == STATUS_ADDR);

   ////////////////////////////////////////////////////////////////////////
   // status: sticky error events plus live conditions

   assign sticky_set = {events.gap_error, events.frame_error, events.parity_error,
                        events.host_timeout_event, events.crc_error};
   assign sticky_clr = wr_status ? reg_req.wdata[STICKY_MSB:STICKY_LSB] : '0;
   // set wins over a write-one clear landing in the same cycle
   assign next_sticky = (sticky & ~sticky_clr) | sticky_set;

   always_ff @(posedge clk) begin
      if (reset) begin
         sticky <= STATUS_RESET[STICKY_MSB:STICKY_LSB];
      end else begin
         sticky <= next_sticky;
      end
   end

   // jabber, queue and carrier bits are live, not latched
   assign status = {1'b0,
                    events.talk_limit_expired,
                    events.talk_limit_triggered,
                    sticky,
                    events.rx_queue_level,
                    events.rx_queue_full,
                    events.rx_queue_empty,
                    events.tx_queue_level,
                    events.tx_queue_full,
                    events.tx_queue_empty,
                    events.carrier_detect,
                    clear_to_send};

   ////////////////////////////////////////////////////////////////////////
   // clear to send

   // full duplex does not wait for a quiet line
   assign next_cts = ctrl.modem_enable && ctrl.request_to_send &&
                     (ctrl.fifo_loopback || !events.carrier_detect);

   always_ff @(posedge clk) begin
      if (reset) begin
         clear_to_send <= 1'b0;
      end else begin
         clear_to_send <= next_cts;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // mask and control registers

   always_ff @(posedge clk) begin
      if (reset) begin
         mask <= MASK_RESET;
      end else if (wr_mask) begin
         mask <= reg_req.wdata & MASK_WRITABLE;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl <= CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl <= reg_req.wdata & CTRL_WRITABLE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // decoded control outputs, one cycle behind the register

   always_ff @(posedge clk) begin
      if (reset) begin
         preamble_byte_count <= CTRL_RESET[14:12] + PREAMBLE_BIAS;
         amplitude_mvpp      <= 10'(CTRL_RESET[8:4]) * AMP_STEP_MVPP;
      end else begin
         preamble_byte_count <= {1'b0, ctrl.preamble_code} + PREAMBLE_BIAS;
         // amplitude range limits are the host's job, code passes as written
         amplitude_mvpp      <= 10'(ctrl.transmit_amplitude) * AMP_STEP_MVPP;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         tx_enable       <= CTRL_RESET[3];
         rx_enable       <= CTRL_RESET[3];
         loopback_enable <= CTRL_RESET[2];
      end else begin
         tx_enable       <= ctrl.modem_enable;
         rx_enable       <= ctrl.modem_enable;
         loopback_enable <= ctrl.fifo_loopback;
      end
   end

   // polarity is carried on ctrl.manchester_polarity to the encoder as is

   ////////////////////////////////////////////////////////////////////////
   // register read port; unmapped addresses read zero

   always_comb begin
      next_rdata = 16'h0000;
      unique case (reg_req.addr)
         STATUS_ADDR: next_rdata = status;
         MASK_ADDR:   next_rdata = mask;
         CTRL_ADDR:   next_rdata = ctrl;
         default:     next_rdata = 16'h0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         reg_rdata    <= 16'h0000;
         reg_rd_valid <= 1'b0;
      end else begin
         reg_rd_valid <= reg_req.rd_en;
         if (reg_req.rd_en) begin
            reg_rdata <= next_rdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt pin

   mdmirq_irq_gen u_irq_gen (
      .clk         (clk),
      .reset       (reset),
      .status      (status),
      .mask        (mask),
      .level_mode  (irq_level_mode),
      .active_low  (irq_active_low),
      .status_read (status_read),
      .irq_pin     (irq_pin),
      .irq_request (irq_request)
   );

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   logic [7:0] last_rd_addr;
   logic       rd_unmapped;

   always_ff @(posedge clk) begin
      if (reset) begin
         last_rd_addr <= 8'h00;
      end else if (reg_req.rd_en) begin
         last_rd_addr <= reg_req.addr;
      end
   end

   assign rd_unmapped = reg_req.rd_en && !(reg_req.addr inside {STATUS_ADDR, MASK_ADDR, CTRL_ADDR});

   property p_reset_values;
      @(posedge clk) disable iff (1'b0)
      reset |=> (mask == MASK_RESET) && (ctrl == CTRL_RESET);
   endproperty

   chk_reset_values: assert property (p_reset_values)
      else $error("mask or control reset value wrong");
   chk_ctrl_reset: assert property (@(posedge clk) disable iff (1'b0)
                                    reset ##1 !reset |-> ctrl.modem_enable && ctrl.transmit_amplitude == 5'h04)
      else $error("control reset fields wrong");
   chk_sticky_hold: assert property (sticky[STICKY_LSB] && !sticky_clr[STICKY_LSB] |=> sticky[STICKY_LSB])
      else $error("sticky event bit lost without clear");
   chk_sticky_set_wins: assert property (events.gap_error && wr_status |=> sticky[STICKY_MSB])
      else $error("event lost against clear");
   chk_cts_follow: assert property (ctrl.request_to_send && ctrl.modem_enable && !events.carrier_detect
                                    |=> clear_to_send)
      else $error("clear to send missing");
   chk_cts_carrier: assert property (events.carrier_detect && !ctrl.fifo_loopback |=> !clear_to_send)
      else $error("clear to send during carrier");
   chk_preamble_count: assert property (##1 preamble_byte_count == {1'b0, $past(ctrl.preamble_code)} + 4'h1)
      else $error("preamble count wrong");
   chk_amp_scale: assert property (##1 amplitude_mvpp == 10'($past(ctrl.transmit_amplitude)) * 10'h019)
      else $error("amplitude scale wrong");
   chk_modem_enable: assert property (!ctrl.modem_enable |=> !tx_enable && !rx_enable)
      else $error("modem disable not applied");
   chk_loopback: assert property (ctrl.fifo_loopback |=> loopback_enable)
      else $error("loopback not applied");
   chk_reserved_zero: assert property (reg_rd_valid && last_rd_addr == MASK_ADDR |-> !reg_rdata[15])
      else $error("reserved mask bit read nonzero");
   chk_ctrl_reserved: assert property (reg_rd_valid && last_rd_addr == CTRL_ADDR |-> reg_rdata[11:9] == 3'h0
                                       && !reg_rdata[1])
      else $error("reserved control bits read nonzero");
   chk_polarity_store: assert property (wr_ctrl |=> ctrl.manchester_polarity == $past(reg_req.wdata[15]))
      else $error("polarity bit not stored");

   ////////////////////////////////////////////////////////////////////////
   // register storage checks

   // a write lands masked to the writable bits, any other cycle leaves the register alone
   chk_mask_store: assert property (wr_mask |=> mask == ($past(reg_req.wdata) & 16'h7fff))
      else $error("mask write not stored");
   chk_mask_hold: assert property (!wr_mask |=> $stable(mask))
      else $error("mask changed without write");
   // reserved control bits never latch, whatever the host writes
   chk_ctrl_store: assert property (wr_ctrl |=> ctrl == ($past(reg_req.wdata) & 16'hf1fd))
      else $error("control write not stored");
   chk_ctrl_hold: assert property (!wr_ctrl |=> $stable(ctrl))
      else $error("control changed without write");

   ////////////////////////////////////////////////////////////////////////
   // status and read port checks

   // the read word is the status seen at the taking edge, masked or not
   chk_status_read: assert property (status_read |=> reg_rd_valid && reg_rdata == $past(status))
      else $error("status read data wrong");
   // a masked event is still recorded for software to find
   chk_masked_record: assert property (events.crc_error && mask[STICKY_LSB] |=> status[STICKY_LSB])
      else $error("masked event not recorded");
   chk_sticky_clear: assert property (sticky_clr[STICKY_LSB] && !events.crc_error |=> !sticky[STICKY_LSB])
      else $error("write one did not clear event");
   chk_unmapped_zero: assert property (rd_unmapped |=> reg_rdata == 16'h0000)
      else $error("unmapped address read nonzero");
   // read data stays put between reads so a slow host can still pick it up
   chk_rdata_hold: assert property (!reg_req.rd_en |=> $stable(reg_rdata))
      else $error("read data changed without read");

   // a lone event reaches the request only while the mask bit at its own position is clear
   for (genvar b = 0; b <= EVENT_MSB; b++) begin : g_gate
      chk_gate_bit: assert property (status == (16'h0001 << b) |=> irq_request != $past(mask[b]))
         else $error("event gated by wrong mask bit");
   end

   ////////////////////////////////////////////////////////////////////////
   // control output checks

   // clear to send needs both the request and an enabled modem
   chk_cts_rts_off: assert property (!ctrl.request_to_send |=> !clear_to_send)
      else $error("clear to send without request");
   chk_cts_disabled: assert property (!ctrl.modem_enable |=> !clear_to_send)
      else $error("clear to send while modem disabled");
   chk_modem_on: assert property (ctrl.modem_enable |=> tx_enable && rx_enable)
      else $error("modem enable not applied");
   // loopback must drop as soon as software clears it, or transmit data keeps echoing
   chk_loopback_off: assert property (!ctrl.fifo_loopback |=> !loopback_enable)
      else $error("loopback left on");

   cov_cts_rise: cover property (!clear_to_send ##1 clear_to_send);
   cov_sticky_clear: cover property (sticky[STICKY_LSB] ##1 wr_status && reg_req.wdata[STICKY_LSB] ##1 !sticky[STICKY_LSB]);
   cov_masked_event: cover property (events.crc_error && mask[8]);

endmodule

`default_nettype wire

// >>> verification/mdmirq_host_model.sv
// host side model: issues register reads and writes toward the block
`default_nettype none

module mdmirq_host_model (
   input  wire logic                    clk,
   output var  mdmirq_pkg::mdmirq_req_t reg_req,
   input  wire logic [15:0]             reg_rdata,
   input  wire logic                    reg_rd_valid
);
   timeunit 1ns;
   timeprecision 100ps;
   import mdmirq_pkg::*;

   initial reg_req = '0;

   ////////////////////////////////////////////////////////////////////////////////
   // the request is held through the taking edge, then released
   task automatic write(input logic [7:0] addr, input logic [15:0] data);
      @(posedge clk);
      #2;
      reg_req.addr  = addr;
      reg_req.wdata = data;
      reg_req.wr_en = 1'b1;
      @(posedge clk);
      #2;
      reg_req.wr_en = 1'b0;
      // released data never repeats the last word
      reg_req.wdata = ~data;
   endtask

   task automatic read(input logic [7:0] addr, output logic [15:0] data);
      int n;
      @(posedge clk);
      #2;
      reg_req.addr  = addr;
      reg_req.rd_en = 1'b1;
      @(posedge clk);
      #2;
      reg_req.rd_en = 1'b0;
      n = 0;
      while (reg_rd_valid !== 1'b1 && n < 4) begin
         @(posedge clk);
         #2;
         n++;
      end
      data = (reg_rd_valid === 1'b1) ? reg_rdata : 16'hxxxx;
   endtask
endmodule

`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the interrupt mask and modem control registers
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import mdmirq_pkg::*;

   logic         clk;
   logic         reset;
   mdmirq_req_t  reg_req;
   logic [15:0]  reg_rdata;
   logic         reg_rd_valid;
   mdmirq_evt_t  events;
   logic         irq_level_mode;
   logic         irq_active_low;
   logic         irq_pin;
   logic         irq_request;
   mdmirq_ctrl_t ctrl;
   logic [3:0]   preamble_byte_count;
   logic [9:0]   amplitude_mvpp;
   logic         tx_enable;
   logic         rx_enable;
   logic         loopback_enable;
   logic         clear_to_send;
   int           err_total;
   int           checks_done;
   int           cycles;
   int           n;
   logic [15:0]  d;
   logic [15:0]  w;
   logic [15:0]  cw [4] = '{16'h0049, 16'h0049, 16'h004d, 16'h0041};
   logic         cd [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
   logic [3:0]   ex [4] = '{4'b1101, 4'b1100, 4'b1111, 4'b0000};

   mdmirq_top u_mdmirq_top (.clk(clk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .reg_rd_valid(reg_rd_valid), .events(events), .irq_level_mode(irq_level_mode),
      .irq_active_low(irq_active_low), .irq_pin(irq_pin), .irq_request(irq_request), .ctrl(ctrl),
      .preamble_byte_count(preamble_byte_count), .amplitude_mvpp(amplitude_mvpp), .tx_enable(tx_enable),
      .rx_enable(rx_enable), .loopback_enable(loopback_enable), .clear_to_send(clear_to_send));

   mdmirq_host_model u_mdmirq_host_model (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .reg_rd_valid(reg_rd_valid));

   ////////////////////////////////////////////////////////////////////////////////
   always #12.5 clk = ~clk;

   // ceiling well above the few hundred cycles the sequence needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 8000) begin
         err_total++;
         test_done();
      end
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] v;
      u_mdmirq_host_model.read(a, v);
      check(v, exp);
   endtask

   task automatic cyc(input int k);
      repeat (k) begin
         @(posedge clk);
         #2;
      end
   endtask

   // counts cycles with the pin in its asserted level
   task automatic pins(input int k, output int cnt);
      cnt = 0;
      repeat (k) begin
         @(posedge clk);
         #2;
         if (irq_pin === ~irq_active_low) cnt++;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      reset = 1'b1;
      events = '0;
      irq_level_mode = 1'b0;
      irq_active_low = 1'b0;
      repeat (12) @(posedge clk);
      #2;
      reset = 1'b0;
      rd_chk(MASK_ADDR, 16'h0024);
      rd_chk(CTRL_ADDR, 16'h0048);
      check(16'({tx_enable, rx_enable, loopback_enable, clear_to_send}), 16'h000c);
      check(16'(preamble_byte_count), 16'h0001);
      check(16'(amplitude_mvpp), 16'(4 * AMP_STEP_MVPP));
      check(16'(irq_pin), 16'h0000);
      $display("reset values done");

      u_mdmirq_host_model.write(MASK_ADDR, 16'hffff);
      rd_chk(MASK_ADDR, 16'h7fff);
      u_mdmirq_host_model.write(CTRL_ADDR, 16'hffff);
      rd_chk(CTRL_ADDR, 16'hf1fd);
      u_mdmirq_host_model.write(8'h30, 16'h0000);
      rd_chk(8'h30, 16'h0000);
      rd_chk(MASK_ADDR, 16'h7fff);
      $display("reserved bits done");

      // amplitude codes stay within 16..30, the allowed output range
      for (int i = 0; i < 8; i++) begin
         w = {i[0], i[2:0], 3'h0, 5'(16 + 2 * i), 1'b1, i[1], 2'b00};
         u_mdmirq_host_model.write(CTRL_ADDR, w);
         cyc(3);
         check(16'(ctrl), w);
         check(16'(preamble_byte_count), 16'(i + 1));
         check(16'(amplitude_mvpp), 16'((16 + 2 * i) * AMP_STEP_MVPP));
         check(16'(loopback_enable), 16'(i[1]));
      end
      $display("control decode done");

      for (int i = 0; i < 4; i++) begin
         events.carrier_detect = cd[i];
         u_mdmirq_host_model.write(CTRL_ADDR, cw[i]);
         cyc(3);
         check(16'({tx_enable, rx_enable, loopback_enable, clear_to_send}), 16'(ex[i]));
         check(16'(ctrl.request_to_send), 16'h0001);
         u_mdmirq_host_model.read(STATUS_ADDR, d);
         check(d, 16'({cd[i], ex[i][0]}));
      end
      events = '0;
      u_mdmirq_host_model.write(CTRL_ADDR, 16'h0048);
      $display("request to send done");

      for (int k = 1; k < 15; k++) begin
         u_mdmirq_host_model.write(MASK_ADDR, MASK_WRITABLE & ~(16'h0001 << k));
         events = mdmirq_evt_t'(14'h0001 << (k - 1));
         pins(5, n);
         check(16'(n), 16'h0001);
         check(16'(irq_request), 16'h0001);
         events = '0;
         u_mdmirq_host_model.write(STATUS_ADDR, 16'h0001 << k);
         cyc(3);
         check(16'(irq_request), 16'h0000);
         u_mdmirq_host_model.write(MASK_ADDR, MASK_WRITABLE);
         events = mdmirq_evt_t'(14'h0001 << (k - 1));
         pins(5, n);
         check(16'(n), 16'h0000);
         check(16'(irq_request), 16'h0000);
         rd_chk(STATUS_ADDR, 16'h0001 << k);
         events = '0;
         cyc(2);
         rd_chk(STATUS_ADDR, (k >= 8 && k <= 12) ? (16'h0001 << k) : 16'h0000);
         u_mdmirq_host_model.write(STATUS_ADDR, 16'h0001 << k);
         rd_chk(STATUS_ADDR, 16'h0000);
      end
      $display("mask per event done");

      // clear to send is raised by the block itself, so it is reached through the request bit
      u_mdmirq_host_model.write(MASK_ADDR, MASK_WRITABLE & ~16'h0001);
      u_mdmirq_host_model.write(CTRL_ADDR, 16'h0049);
      pins(5, n);
      check(16'(n), 16'h0001);
      check(16'(irq_request), 16'h0001);
      $display("clear to send gate done");

      // pin polarity and mode only change under reset, which also clears the earlier state
      reset = 1'b1;
      cyc(2);
      irq_active_low = 1'b1;
      irq_level_mode = 1'b1;
      cyc(2);
      reset = 1'b0;
      check(16'(irq_pin), 16'h0001);
      rd_chk(MASK_ADDR, 16'h0024);
      rd_chk(CTRL_ADDR, 16'h0048);
      u_mdmirq_host_model.write(MASK_ADDR, MASK_WRITABLE & ~16'h0100);
      events.crc_error = 1'b1;
      cyc(1);
      events.crc_error = 1'b0;
      pins(5, n);
      check(16'(n), 16'h0005);
      rd_chk(STATUS_ADDR, 16'h0100);
      cyc(2);
      check(16'(irq_pin), 16'h0001);
      check(16'(irq_request), 16'h0001);
      u_mdmirq_host_model.write(STATUS_ADDR, 16'h0100);
      cyc(3);
      check(16'(irq_request), 16'h0000);
      $display("level mode done");
      test_done();
   end
endmodule

`default_nettype wire
